// ### design/hbsi_defs.svh
`ifndef HBSI_DEFS_SVH
`define HBSI_DEFS_SVH

// Command codes in the upper nibble of the command byte
`define HBSI_CMD_RESET 4'h0
`define HBSI_CMD_STATUS 4'h1
`define HBSI_CMD_WRITE 4'h2
`define HBSI_CMD_IDENT 4'h3
`define HBSI_CMD_SELECT 4'h4
`define HBSI_CMD_DIS_INT 4'h5
`define HBSI_CMD_ENA_INT 4'h6
`define HBSI_CMD_READ 4'h7

// Status latch bit positions
`define HBSI_ST_IO 7
`define HBSI_ST_BUSY 6
`define HBSI_ST_CD 5
`define HBSI_ST_MSG 4
`define HBSI_ST_REQ 3
`define HBSI_ST_LATCHED_TRANSFER_ACK 2
`define HBSI_ST_HPERR 1
`define HBSI_ST_DPERR 0

// Reset values
`define HBSI_MASK_RST 1'b1
`define HBSI_BYTE_RST 8'h00

`endif

// ### design/hbsi_pkg.sv
package hbsi_pkg;

  typedef struct packed {
    logic [3:0] code;
    logic [3:0] addr;
  } hbsi_cmd_t;

  typedef struct packed {
    logic io;
    logic busy;
    logic cd;
    logic msg;
    logic req;
  } hbsi_disk_stat_t;

  typedef enum logic [1:0] {
    HBSI_IDLE = 2'b00,
    HBSI_STB = 2'b01,
    HBSI_ACK = 2'b10
  } hbsi_state_t;

endpackage

// ### design/hbsi_top.sv
`timescale 1ns/1ps
`include "hbsi_defs.svh"

// Notes on behaviour
// - Respond only when address matches rear switches
// - Odd parity generated and checked on transfers
// - Parity over sixteen lines, sampled strobe leading
// - Parity interrupt regardless of address or mask
// - Bad parity discards command, sets error flag
// - Switch enables or disables host parity checking
// - Loopback switch echoes written byte, disk idle
// - Command byte: code high, address low
// - All commands by strobe one, eight valid
// - Decode the eight command codes
// - Enable clears mask, disable sets mask
// - Mask set at power-up and software reset
// - Select sets latch, controller clears it
// - Identity read returns fixed code
// - Data read/write sets ack latch, disk clears
// - Status read returns status latch
// - Status bit order io busy cd msg req...
// - Software reset returns mask, flags, latches and request to power-up
// - Check disk data parity, set error flag
// - Acknowledge returns response byte with address
// - Request and response clear at ack trailing edge
module hbsi_top #(
  parameter logic [7:0] IDENT_CODE = 8'h5A // Arbitrary value
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] ADDR_SWITCH,
  input wire logic PARITY_EN_SWITCH,
  input wire logic LOOPBACK_SWITCH,
  input wire logic COMMAND_STROBE_ONE,
  input wire logic INT_ACKNOWLEDGE,
  input wire logic [7:0] HOST_CMD,
  input wire logic [7:0] HOST_DATA_IN,
  input wire logic HOST_PARITY_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_PARITY_OUT,
  output logic HOST_DATA_OE,
  output logic HOST_INT_REQ,
  input wire logic DISK_IO,
  input wire logic DISK_BUSY,
  input wire logic DISK_CD,
  input wire logic DISK_MSG,
  input wire logic DISK_REQ,
  input wire logic [7:0] DISK_DATA_IN,
  input wire logic DISK_PARITY_IN,
  input wire logic DISK_SEL_CLEAR,
  input wire logic DISK_ACK_CLEAR,
  input wire logic DISK_INT_EVENT,
  output logic [7:0] DISK_DATA_OUT,
  output logic DISK_DATA_OE,
  output logic DISK_SELECT,
  output logic DISK_ACK,
  output logic DISK_RESET
);

  // Three-stage synchronisers for strobe, acknowledge, clear, event, REQ, BUSY and parity-switch inputs
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] clean_q;
  assign raw_in = {COMMAND_STROBE_ONE, INT_ACKNOWLEDGE, DISK_SEL_CLEAR,
                   DISK_ACK_CLEAR, DISK_INT_EVENT, DISK_REQ,
                   DISK_BUSY, PARITY_EN_SWITCH};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          clean_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // A change counts only once stages two and three agree
          if (s2_q[gi] == s3_q[gi]) begin
            clean_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  wire strobe_lvl = clean_q[7];
  wire int_acknowledge_lvl = clean_q[6];
  wire sel_clr = clean_q[5];
  wire ack_clr = clean_q[4];
  wire disk_evt_lvl = clean_q[3];
  wire par_en = clean_q[0];

  logic strobe_d1_q;
  logic int_acknowledge_d1_q;
  logic evt_d1_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      strobe_d1_q <= 1'b0;
      int_acknowledge_d1_q <= 1'b0;
      evt_d1_q <= 1'b0;
    end else begin
      strobe_d1_q <= strobe_lvl;
      int_acknowledge_d1_q <= int_acknowledge_lvl;
      evt_d1_q <= disk_evt_lvl;
    end
  end
  wire strobe_rise = strobe_lvl & ~strobe_d1_q;
  wire strobe_fall = ~strobe_lvl & strobe_d1_q;
  wire int_acknowledge_rise = int_acknowledge_lvl & ~int_acknowledge_d1_q;
  wire int_acknowledge_fall = ~int_acknowledge_lvl & int_acknowledge_d1_q;
  wire disk_evt = disk_evt_lvl & ~evt_d1_q;

  // Bus lines are held by the host while the strobe stands, so sampling
  // after the synchroniser delay still sees the leading-edge values.
  hbsi_pkg::hbsi_cmd_t cmd;
  assign cmd = hbsi_pkg::hbsi_cmd_t'(HOST_CMD);
  wire par_ok = ^{HOST_CMD, HOST_DATA_IN, HOST_PARITY_IN};
  wire par_bad = par_en & ~par_ok;
  wire addr_hit = cmd.addr == ADDR_SWITCH;
  wire cmd_take = strobe_rise & ~par_bad & addr_hit;

  wire is_reset = cmd_take & (cmd.code == `HBSI_CMD_RESET);
  wire is_status = cmd_take & (cmd.code == `HBSI_CMD_STATUS);
  wire is_write = cmd_take & (cmd.code == `HBSI_CMD_WRITE);
  wire is_ident = cmd_take & (cmd.code == `HBSI_CMD_IDENT);
  wire is_select = cmd_take & (cmd.code == `HBSI_CMD_SELECT);
  wire is_dis = cmd_take & (cmd.code == `HBSI_CMD_DIS_INT);
  wire is_ena = cmd_take & (cmd.code == `HBSI_CMD_ENA_INT);
  wire is_read = cmd_take & (cmd.code == `HBSI_CMD_READ);
  // Codes 8..F match none of the above and change nothing
  wire soft_rst = is_reset;

  hbsi_pkg::hbsi_disk_stat_t dstat_q;
  logic disk_perr_q;
  logic host_perr_q;
  logic mask_q;
  logic sel_q;
  logic ack_q;
  logic [7:0] wdata_q;
  logic [7:0] loop_q;
  logic [7:0] rdata_q;
  logic rd_oe_q;
  logic int_pend_q;
  logic int_acknowledge_active_q;
  logic perr_int_q;

  // Disk status is captured every cycle into the latch
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      dstat_q <= '0;
    end else begin
      dstat_q <= {DISK_IO, clean_q[1], DISK_CD, DISK_MSG, clean_q[2]};
    end
  end

  wire disk_par_bad = ~(^{DISK_DATA_IN, DISK_PARITY_IN});
  wire [7:0] status_byte = {dstat_q.io, dstat_q.busy, dstat_q.cd,
                            dstat_q.msg, dstat_q.req, ack_q,
                            host_perr_q, disk_perr_q};

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || soft_rst) begin
      mask_q <= `HBSI_MASK_RST;
    end else if (is_ena) begin
      mask_q <= 1'b0;
    end else if (is_dis) begin
      mask_q <= 1'b1;
    end
  end

  // Error flags clear on status read; a new error in that cycle wins
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || soft_rst) begin
      host_perr_q <= 1'b0;
      disk_perr_q <= 1'b0;
    end else begin
      if (strobe_rise && par_bad) begin
        host_perr_q <= 1'b1;
      end else if (is_status) begin
        host_perr_q <= 1'b0;
      end
      if (ack_q && disk_evt_lvl && !LOOPBACK_SWITCH && disk_par_bad) begin
        disk_perr_q <= 1'b1;
      end else if (is_status) begin
        disk_perr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || soft_rst) begin
      sel_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      if (is_select && !LOOPBACK_SWITCH) begin
        sel_q <= 1'b1;
      end else if (sel_clr) begin
        sel_q <= 1'b0;
      end
      if ((is_read || is_write) && !LOOPBACK_SWITCH) begin
        ack_q <= 1'b1;
      end else if (ack_clr) begin
        ack_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || soft_rst) begin
      wdata_q <= `HBSI_BYTE_RST;
      loop_q <= `HBSI_BYTE_RST;
    end else if (is_write) begin
      if (LOOPBACK_SWITCH) begin
        loop_q <= HOST_DATA_IN;
      end else begin
        wdata_q <= HOST_DATA_IN;
      end
    end
  end

  // Read data selection for the answer to a strobe or an acknowledge
  wire [7:0] resp_byte = {dstat_q.io, host_perr_q | disk_perr_q,
                          dstat_q.cd, dstat_q.msg, ADDR_SWITCH};
  logic [7:0] sel_byte;
  always_comb begin
    sel_byte = `HBSI_BYTE_RST;
    if (is_status) begin
      sel_byte = status_byte;
    end else if (is_ident) begin
      sel_byte = IDENT_CODE;
    end else if (is_read) begin
      sel_byte = LOOPBACK_SWITCH ? loop_q : DISK_DATA_IN;
    end
  end
  wire rd_take = is_status | is_ident | is_read;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_q <= `HBSI_BYTE_RST;
      rd_oe_q <= 1'b0;
      int_acknowledge_active_q <= 1'b0;
    end else if (int_acknowledge_rise && int_pend_q) begin
      rdata_q <= resp_byte;
      rd_oe_q <= 1'b1;
      int_acknowledge_active_q <= 1'b1;
    end else if (rd_take) begin
      rdata_q <= sel_byte;
      rd_oe_q <= 1'b1;
    end else if (int_acknowledge_fall && int_acknowledge_active_q) begin
      rdata_q <= `HBSI_BYTE_RST;
      rd_oe_q <= 1'b0;
      int_acknowledge_active_q <= 1'b0;
    end else if (strobe_fall && !int_acknowledge_active_q) begin
      rd_oe_q <= 1'b0;
    end
  end

  // Pending request: disk events gated by the mask, parity never gated
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || soft_rst) begin
      int_pend_q <= 1'b0;
      perr_int_q <= 1'b0;
    end else begin
      if (strobe_rise && par_bad) begin
        perr_int_q <= 1'b1;
      end else if (int_acknowledge_fall && int_acknowledge_active_q) begin
        perr_int_q <= 1'b0;
      end
      if ((disk_evt && !mask_q) || (strobe_rise && par_bad)) begin
        int_pend_q <= 1'b1;
      end else if (int_acknowledge_fall && int_acknowledge_active_q) begin
        int_pend_q <= 1'b0;
      end
    end
  end

  assign HOST_DATA_OUT = rdata_q;
  assign HOST_PARITY_OUT = ~(^rdata_q);
  assign HOST_DATA_OE = rd_oe_q;
  assign HOST_INT_REQ = int_pend_q | perr_int_q;
  assign DISK_DATA_OUT = wdata_q;
  assign DISK_DATA_OE = ack_q & ~dstat_q.io;
  assign DISK_SELECT = sel_q;
  assign DISK_ACK = ack_q;

  // Pulse the controller reset for one cycle on software reset
  logic disk_rst_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      disk_rst_q <= 1'b1;
    end else begin
      disk_rst_q <= soft_rst;
    end
  end
  assign DISK_RESET = disk_rst_q;

endmodule

// ### verif/hbsi_disk_model.sv
`timescale 1ns/1ps
module hbsi_disk_model (
  input wire logic clk,
  input wire logic sel,
  input wire logic ack,
  output logic sel_clr,
  output logic ack_clr
);
  logic [4:0] sel_q = 5'h00;
  logic [4:0] ack_q = 5'h00;
  // Slow controller: a latch is only cleared after standing 16 cycles
  always @(posedge clk) begin
    sel_q <= sel ? sel_q + {4'h0, ~sel_q[4]} : 5'h00;
    ack_q <= ack ? ack_q + {4'h0, ~ack_q[4]} : 5'h00;
  end
  assign sel_clr = sel_q[4];
  assign ack_clr = ack_q[4];
endmodule

// ### verif/hbsi_top_monitor.sv
`timescale 1ns/1ps
module hbsi_top_monitor #(
  parameter logic [7:0] IDENT_CODE = 8'h5A // Arbitrary value
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] ADDR_SWITCH,
  input wire logic LOOPBACK_SWITCH,
  input wire logic COMMAND_STROBE_ONE,
  input wire logic INT_ACKNOWLEDGE,
  input wire logic [7:0] HOST_CMD,
  input wire logic [7:0] HOST_DATA_OUT,
  input wire logic HOST_PARITY_OUT,
  input wire logic HOST_DATA_OE,
  input wire logic HOST_INT_REQ,
  input wire logic DISK_IO,
  input wire logic DISK_SELECT,
  input wire logic DISK_ACK,
  input wire logic DISK_RESET
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire logic hit = COMMAND_STROBE_ONE && HOST_CMD[3:0] == ADDR_SWITCH;
  wire logic [3:0] code = HOST_CMD[7:4];

  a_par_odd: assert property (^{HOST_DATA_OUT, HOST_PARITY_OUT})
    else $error("host parity out not odd");
  a_rst_state: assert property ($rose(RST_N) |-> DISK_RESET &&
    !HOST_INT_REQ && !DISK_SELECT ##1 !DISK_RESET)
    else $error("bad state after reset");
  a_sw_reset: assert property ($rose(DISK_RESET) |-> hit &&
    code == 4'h0 ##1 !DISK_RESET)
    else $error("bad disk reset pulse");
  a_sel_cause: assert property ($rose(DISK_SELECT) |-> hit &&
    code == 4'h4 && !LOOPBACK_SWITCH)
    else $error("select set without command");
  a_ack_cause: assert property ($rose(DISK_ACK) |-> hit &&
    (code == 4'h2 || code == 4'h7) && !LOOPBACK_SWITCH)
    else $error("ack set without data command");
  a_ident_byte: assert property ($rose(HOST_DATA_OE) && hit &&
    !INT_ACKNOWLEDGE && code == 4'h3 |-> HOST_DATA_OUT == IDENT_CODE)
    else $error("wrong identity byte");
  a_int_resp: assert property ($rose(HOST_DATA_OE) && INT_ACKNOWLEDGE |->
    HOST_DATA_OUT[3:0] == ADDR_SWITCH && HOST_DATA_OUT[7] == DISK_IO)
    else $error("wrong response byte");
  a_int_clear: assert property ($fell(INT_ACKNOWLEDGE) && HOST_INT_REQ
    |-> ##[1:8] !HOST_INT_REQ && !HOST_DATA_OE)
    else $error("request not cleared after ack");
  c_int_acknowledge: cover property ($rose(HOST_DATA_OE) && INT_ACKNOWLEDGE);
  c_sel: cover property ($rose(DISK_SELECT));
  c_swrst: cover property ($rose(DISK_RESET));
endmodule

bind hbsi_top hbsi_top_monitor #(.IDENT_CODE(IDENT_CODE)) i_hbsi_top_monitor (
  .CLK_SYS, .RST_N, .ADDR_SWITCH, .LOOPBACK_SWITCH, .COMMAND_STROBE_ONE,
  .INT_ACKNOWLEDGE, .HOST_CMD, .HOST_DATA_OUT, .HOST_PARITY_OUT,
  .HOST_DATA_OE, .HOST_INT_REQ, .DISK_IO, .DISK_SELECT, .DISK_ACK,
  .DISK_RESET
);

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] idc = 8'h3E; // Arbitrary identity value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pen = 1'b1, lb = 1'b0, stb = 1'b0, ia = 1'b0, ev = 1'b0, dbad = 1'b0;
  logic [7:0] hcmd = 8'h00, hdin = 8'h00, hout, dout, rd;
  logic [4:0] ds = 5'h15;
  logic hpar = 1'b1;
  logic hpo, hint, sel, ack, sclr, aclr, oe, doe, rdoe;
  int n_errors = 0;
  int checks = 0;
  always #20 clk = ~clk;
  hbsi_top #(.IDENT_CODE(idc)) i_hbsi_top (
    .CLK_SYS(clk), .RST_N(rst_n), .ADDR_SWITCH(4'h9),
    .PARITY_EN_SWITCH(pen), .LOOPBACK_SWITCH(lb), .COMMAND_STROBE_ONE(stb),
    .INT_ACKNOWLEDGE(ia), .HOST_CMD(hcmd), .HOST_DATA_IN(hdin),
    .HOST_PARITY_IN(hpar), .HOST_DATA_OUT(hout), .HOST_PARITY_OUT(hpo),
    .HOST_DATA_OE(oe), .HOST_INT_REQ(hint), .DISK_IO(ds[4]),
    .DISK_BUSY(ds[3]), .DISK_CD(ds[2]), .DISK_MSG(ds[1]), .DISK_REQ(ds[0]),
    .DISK_DATA_IN(hdin), .DISK_PARITY_IN(~^hdin ^ dbad),
    .DISK_SEL_CLEAR(sclr), .DISK_ACK_CLEAR(aclr), .DISK_INT_EVENT(ev),
    .DISK_DATA_OUT(dout), .DISK_DATA_OE(doe), .DISK_SELECT(sel),
    .DISK_ACK(ack), .DISK_RESET()
  );
  hbsi_disk_model i_hbsi_disk_model (.clk(clk), .sel(sel), .ack(ack),
    .sel_clr(sclr), .ack_clr(aclr));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] d = 8'h00,
      input logic bad = 1'b0);
    hcmd = c;
    hdin = d;
    hpar = ~^{c, d} ^ bad;
    stb = 1'b1;
    step(8);
    rd = hout;
    rdoe = oe;
    chk({7'h00, ^{hout, hpo}}, 8'h01);
    stb = 1'b0;
    step(5);
  endtask
  task automatic pulse();
    ev = 1'b1;
    step(6);
    ev = 1'b0;
    step(8);
  endtask
  task automatic int_acknowledge(input logic [7:0] exp);
    ia = 1'b1;
    step(8);
    chk(hout, exp);
    ia = 1'b0;
    step(8);
    chk({7'h00, hint}, 8'h00);
  endtask
  function automatic logic [7:0] lat();
    return {5'h00, sel, ack, hint};
  endfunction
  task automatic end_of_test();
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_status();
    ds = 5'h0A;
    step(4);
    cmd(8'h19);
    chk(rd, 8'h50);
    chk({7'h00, rdoe}, 8'h01);
    chk({7'h00, oe}, 8'h00);
    ds = 5'h15;
    step(4);
    cmd(8'h19);
    chk(rd, 8'hA8);
    cmd(8'h39);
    chk(rd, idc);
  endtask
  task automatic t_foreign();
    cmd(8'h4A);
    chk(lat(), 8'h00);
    for (int c = 8; c < 16; c++) begin
      cmd({c[3:0], 4'h9});
      chk(lat(), 8'h00);
    end
    cmd(8'h49);
    chk(lat(), 8'h04);
    chk({7'h00, rdoe}, 8'h00);
    step(40);
    chk(lat(), 8'h00);
  endtask
  task automatic t_mask();
    pulse();
    chk(lat(), 8'h00);
    cmd(8'h69);
    pulse();
    chk(lat(), 8'h01);
    int_acknowledge(8'hA9);
    cmd(8'h59);
    pulse();
    chk(lat(), 8'h00);
  endtask
  task automatic t_parity();
    cmd(8'h48, 8'h00, 1'b1);
    chk(lat(), 8'h01);
    int_acknowledge(8'hE9);
    cmd(8'h19);
    chk(rd, 8'hAA);
    pen = 1'b0;
    step(4);
    cmd(8'h49, 8'h00, 1'b1);
    chk(lat(), 8'h04);
    pen = 1'b1;
    step(40);
  endtask
  task automatic t_write();
    dbad = 1'b1;
    cmd(8'h29, 8'hA5);
    chk(lat(), 8'h02);
    chk(dout, 8'hA5);
    chk({7'h00, doe}, 8'h00);
    pulse();
    step(40);
    dbad = 1'b0;
    cmd(8'h19);
    chk(rd, 8'hA9);
    cmd(8'h79);
    chk(lat(), 8'h02);
    step(40);
  endtask
  task automatic t_loop();
    cmd(8'h69);
    cmd(8'h09);
    pulse();
    chk(lat(), 8'h00);
    lb = 1'b1;
    cmd(8'h29, 8'h3C);
    chk(lat(), 8'h00);
    cmd(8'h79);
    chk(rd, 8'h3C);
    lb = 1'b0;
  endtask

  initial begin
    step(10);
    rst_n = 1'b1;
    step(5);
    t_status();
    t_foreign();
    t_mask();
    t_parity();
    t_write();
    t_loop();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule
